/* File: rtl/tpl_lock_bank.sv */
// Transport parameter lock bank with stream format selection.
// Assumes synchronous inputs, one request per port per cycle.

module tpl_lock_bank
    import tpl_pkg::*;
(
    // Clock, reset and enable.
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  ce,
    // Setting writes from host or internal sequencer.
    input  wire logic                  setReq,
    input  wire logic                  setInternal,
    input  wire tpl_setting_e          setSel,
    input  wire logic [31:0]           setData,
    output logic                       setDone,
    output logic                       setErr,
    // Setting reads.
    input  wire logic                  rdReq,
    input  wire tpl_setting_e          rdSel,
    output logic      [31:0]           rdData,
    output logic                       rdValid,
    // Acquisition commands.
    input  wire logic                  captureBeginReq,
    input  wire logic                  transferBeginReq,
    input  wire logic                  captureEnd,
    output logic                       captureBeginGo,
    output logic                       transferBeginGo,
    output logic                       cmdRefused,
    // Device conditions.
    input  wire logic                  lineScan,
    input  wire logic                  autoPrefer,
    input  wire logic                  headerVariable,
    input  wire tpl_diag_e             diagnosticPayloadFormat,
    // Settings and status seen by streaming logic.
    output logic                       transportParamLock,
    output logic      [NUM_GROUPS-1:0] groupLocked,
    output logic      [15:0]           pixelWidth,
    output logic      [15:0]           pixelHeight,
    output logic      [15:0]           pixelEncoding,
    output logic                       enlargedPayload,
    output logic                       containerFormatActive,
    output logic                       streamAsContainer,
    output logic      [31:0]           bufferByteCount,
    // Header preview and flow map table.
    input  wire logic [HDR_IDX_W-1:0]  hdrIdx,
    output logic      [31:0]           hdrWord,
    output logic                       hdrAvail,
    input  wire logic [FLOW_IDX_W-1:0] flowIdx,
    output logic      [31:0]           flowWord,
    output logic                       flowAvail
);

    tpl_state_e            state;
    tpl_state_e            next_state;
    tpl_group_e            lockGroupSelect;
    tpl_mode_e             containerFormatMode;
    logic [NUM_GROUPS-1:0] lockGroupState;
    logic [CH_W-1:0]       streamChannelPick;
    logic                  wrTake;
    logic                  wrOk;
    logic                  lockWr;
    logic                  unlockWr;
    logic [31:0]           chCount [NUM_CH];
    logic [31:0]           chHdr   [NUM_CH];
    logic [31:0]           chFlow  [NUM_CH];

    tpl_cfg_if cfg ();

    assign wrTake = ce && setReq;
    assign lockWr = wrTake && wrOk && setSel == SET_LOCK;
    assign unlockWr = lockWr && setData != LOCK_ON;

    // Any non-open phase means the critical settings are frozen.
    assign transportParamLock = state != ST_OPEN;

    // A group is frozen only while the global lock stands.
    always_comb begin
        for (int g = 0; g < NUM_GROUPS; g++) begin
            groupLocked[g] = transportParamLock && lockGroupState[g];
        end
    end

    // Acceptance check of a write, the same for host and internal writers except on the lock setting.
    always_comb begin
        case (setSel)
            SET_LOCK: begin
                // Internal logic may not touch the lock itself.
                wrOk = !setInternal && setData <= LOCK_ON
                    && !(state == ST_RUNNING && setData != LOCK_ON);
            end
            SET_GROUP_SEL: begin
                wrOk = setData < 32'(NUM_GROUPS);
            end
            SET_GROUP_STATE: begin
                wrOk = !transportParamLock;
            end
            SET_WIDTH: begin
                wrOk = !groupLocked[GRP_IMAGE];
            end
            SET_HEIGHT: begin
                wrOk = !groupLocked[GRP_IMAGE] || lineScan;
            end
            SET_ENCODING: begin
                wrOk = !groupLocked[GRP_ENCODING]
                    && (!groupLocked[GRP_BPP]
                        || setData[BPP_MSB:BPP_LSB]
                           == pixelEncoding[BPP_MSB:BPP_LSB]);
            end
            SET_ENLARGED: begin
                wrOk = !groupLocked[GRP_ENLARGED];
            end
            SET_MODE: begin
                // Stream format is streaming channel setup, so it locks.
                wrOk = !transportParamLock
                    && setData <= 32'(MODE_AUTO);
            end
            SET_CHANNEL: begin
                wrOk = setData < 32'(NUM_CH);
            end
            default: begin
                wrOk = 1'b0;
            end
        endcase
    end

    // Lock phase: begins are only honoured once the settings are locked.
    always_comb begin
        next_state = state;
        case (state)
            ST_OPEN: begin
                if (lockWr && !unlockWr) begin
                    next_state = ST_LOCKED;
                end
            end
            ST_LOCKED: begin
                if (unlockWr) begin
                    next_state = ST_OPEN;
                end else if (captureBeginReq) begin
                    next_state = ST_RUNNING;
                end
            end
            ST_RUNNING: begin
                if (captureEnd) begin
                    next_state = ST_LOCKED;
                end
            end
            default: begin
                next_state = ST_OPEN;
            end
        endcase
    end

    // Phase register; reset leaves every setting changeable.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= ST_OPEN;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // Write answer: one pulse per taken write, error when refused.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            setDone <= 1'b0;
            setErr  <= 1'b0;
        end else if (ce) begin
            setDone <= setReq;
            setErr  <= setReq && !wrOk;
        end
    end

    // Stored settings change only on an accepted write.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lockGroupSelect     <= GRP_IMAGE;
            lockGroupState      <= GROUP_STATE_RST;
            pixelWidth          <= WIDTH_RST;
            pixelHeight         <= HEIGHT_RST;
            pixelEncoding       <= ENCODING_RST;
            enlargedPayload     <= 1'b0;
            containerFormatMode <= MODE_OFF;
            streamChannelPick   <= '0;
        end else if (wrTake && wrOk) begin
            case (setSel)
                SET_GROUP_SEL: begin
                    lockGroupSelect <= tpl_group_e'(setData[GROUP_W-1:0]);
                end
                SET_GROUP_STATE: begin
                    lockGroupState[lockGroupSelect] <= setData[0];
                end
                SET_WIDTH: begin
                    pixelWidth <= setData[15:0];
                end
                SET_HEIGHT: begin
                    pixelHeight <= setData[15:0];
                end
                SET_ENCODING: begin
                    pixelEncoding <= setData[15:0];
                end
                SET_ENLARGED: begin
                    enlargedPayload <= setData[0];
                end
                SET_MODE: begin
                    containerFormatMode <= tpl_mode_e'(setData[1:0]);
                end
                SET_CHANNEL: begin
                    streamChannelPick <= setData[CH_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Automatic leaves the choice to the streaming side's preference.
    assign containerFormatActive = containerFormatMode == MODE_ON
        || (containerFormatMode == MODE_AUTO && autoPrefer);

    // Only the diagnostic format may override the container mode.
    always_comb begin
        case (diagnosticPayloadFormat)
            DIAG_OFF: begin
                streamAsContainer = containerFormatActive;
            end
            DIAG_CONTAINER: begin
                streamAsContainer = 1'b1;
            end
            default: begin
                streamAsContainer = 1'b0;
            end
        endcase
    end

    // Begin commands: refused until the transport settings are locked.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            captureBeginGo  <= 1'b0;
            transferBeginGo <= 1'b0;
            cmdRefused      <= 1'b0;
        end else if (ce) begin
            captureBeginGo  <= captureBeginReq && transportParamLock;
            transferBeginGo <= transferBeginReq && transportParamLock;
            cmdRefused      <= (captureBeginReq || transferBeginReq)
                            && !transportParamLock;
        end
    end

    // Settings handed to the per channel calculators.
    assign cfg.width       = pixelWidth;
    assign cfg.height      = pixelHeight;
    assign cfg.bpp         = pixelEncoding[BPP_MSB:BPP_LSB];
    assign cfg.enlarged    = enlargedPayload;
    assign cfg.containerOn = containerFormatActive;
    assign cfg.freeze      = transportParamLock;

    // One calculator per stream channel keeps the counts apart.
    for (genvar c = 0; c < NUM_CH; c++) begin : gCh
        tpl_payload_calc #(
            .CH (c)
        ) uCalc (
            .clk       (clk),
            .sys_rst   (sys_rst),
            .ce        (ce),
            .cfg       (cfg),
            .hdrIdx    (hdrIdx),
            .flowIdx   (flowIdx),
            .byteCount (chCount[c]),
            .hdrWord   (chHdr[c]),
            .flowWord  (chFlow[c])
        );
    end

    // The picked channel is shown; all muxed words are flop outputs.
    assign bufferByteCount = chCount[streamChannelPick];
    assign hdrWord  = chHdr[streamChannelPick];
    assign flowWord = chFlow[streamChannelPick];

    // A fully variable container has no meaningful preview.
    assign hdrAvail  = containerFormatActive && !headerVariable;
    assign flowAvail = containerFormatActive;

    // Read answer one cycle after the request.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdData  <= 32'h0;
            rdValid <= 1'b0;
        end else if (ce) begin
            rdValid <= rdReq;
            case (rdSel)
                SET_LOCK: begin
                    rdData <= 32'(transportParamLock);
                end
                SET_GROUP_SEL: begin
                    rdData <= 32'(lockGroupSelect);
                end
                SET_GROUP_STATE: begin
                    rdData <= 32'(lockGroupState[lockGroupSelect]);
                end
                SET_WIDTH: begin
                    rdData <= 32'(pixelWidth);
                end
                SET_HEIGHT: begin
                    rdData <= 32'(pixelHeight);
                end
                SET_ENCODING: begin
                    rdData <= 32'(pixelEncoding);
                end
                SET_ENLARGED: begin
                    rdData <= 32'(enlargedPayload);
                end
                SET_MODE: begin
                    rdData <= 32'(containerFormatMode);
                end
                SET_CHANNEL: begin
                    rdData <= 32'(streamChannelPick);
                end
                SET_BYTE_COUNT: begin
                    rdData <= bufferByteCount;
                end
                SET_STATUS: begin
                    rdData <= 32'(containerFormatActive);
                end
                default: begin
                    rdData <= 32'h0;
                end
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence lockedWrite(tpl_setting_e s);
        ce && setReq && setSel == s;
    endsequence

    begin_refuse_a: assert property (
        ce && captureBeginReq && !transportParamLock
        |=> cmdRefused && !captureBeginGo)
        else $error("Capture begin accepted while unlocked.");
    xfer_refuse_a: assert property (
        ce && transferBeginReq && !transportParamLock
        |=> cmdRefused && !transferBeginGo)
        else $error("Transfer begin accepted while unlocked.");
    run_lock_a: assert property (
        lockedWrite(SET_LOCK) and (state == ST_RUNNING && setData == 32'h0)
        |=> transportParamLock && setErr)
        else $error("Lock released during acquisition.");
    count_static_a: assert property (
        transportParamLock |=> $stable(bufferByteCount)
            || $changed(streamChannelPick))
        else $error("Byte count moved while locked.");
    width_reject_a: assert property (
        lockedWrite(SET_WIDTH) and groupLocked[GRP_IMAGE]
        |=> setErr && $stable(pixelWidth))
        else $error("Locked width write not rejected.");
    internal_block_a: assert property (
        lockedWrite(SET_ENLARGED) and (setInternal
            && groupLocked[GRP_ENLARGED])
        |=> setErr ##1 enlargedPayload == $past(enlargedPayload, 2))
        else $error("Internal change passed a locked group.");
    bpp_keep_a: assert property (
        lockedWrite(SET_ENCODING) and (!groupLocked[GRP_ENCODING]
            && setData[BPP_MSB:BPP_LSB] == pixelEncoding[BPP_MSB:BPP_LSB])
        |=> !setErr && pixelEncoding == $past(setData[15:0]))
        else $error("Same-size encoding change refused.");
    status_mode_a: assert property (
        (containerFormatMode == MODE_ON |-> containerFormatActive)
        and (containerFormatMode == MODE_OFF |-> !containerFormatActive))
        else $error("Status disagrees with mode.");
    hdr_gone_a: assert property (
        containerFormatActive && headerVariable |-> !hdrAvail)
        else $error("Variable header offered.");
    flow_there_a: assert property (
        containerFormatActive |-> flowAvail)
        else $error("Flow table missing.");

endmodule

/* File: rtl/tpl_pkg.sv */
// Constants, encodings and reset values of the transport lock bank.
// Assumes one 25 MHz clock domain; shared by the bank and its calculators.
package tpl_pkg;

    // Sizes of the bank.
    localparam int NUM_CH     = 2;
    localparam int CH_W       = 1;
    localparam int NUM_GROUPS = 5;
    localparam int GROUP_W    = 3;
    localparam int HDR_WORDS  = 8;
    localparam int HDR_IDX_W  = 3;
    localparam int FLOW_WORDS = 4;
    localparam int FLOW_IDX_W = 2;

    // Lock groups picked by the lock group selector.
    typedef enum logic [2:0] {
        GRP_IMAGE    = 3'h0,
        GRP_ENCODING = 3'h1,
        GRP_BPP      = 3'h2,
        GRP_ENLARGED = 3'h3,
        GRP_DEVICE   = 3'h4
    } tpl_group_e;

    // Settings reached through the write and read request ports.
    typedef enum logic [3:0] {
        SET_LOCK        = 4'h0,
        SET_GROUP_SEL   = 4'h1,
        SET_GROUP_STATE = 4'h2,
        SET_WIDTH       = 4'h3,
        SET_HEIGHT      = 4'h4,
        SET_ENCODING    = 4'h5,
        SET_ENLARGED    = 4'h6,
        SET_MODE        = 4'h7,
        SET_CHANNEL     = 4'h8,
        SET_BYTE_COUNT  = 4'h9,
        SET_STATUS      = 4'ha
    } tpl_setting_e;

    // Container format mode and diagnostic payload format.
    typedef enum logic [1:0] {
        MODE_OFF  = 2'h0,
        MODE_ON   = 2'h1,
        MODE_AUTO = 2'h2
    } tpl_mode_e;
    typedef enum logic [1:0] {
        DIAG_OFF       = 2'h0,
        DIAG_MULTIPART = 2'h1,
        DIAG_CONTAINER = 2'h2
    } tpl_diag_e;

    // Lock phases of the transport parameters.
    typedef enum logic [1:0] {
        ST_OPEN    = 2'h0,
        ST_LOCKED  = 2'h1,
        ST_RUNNING = 2'h2
    } tpl_state_e;

    // Reset values; bits per pixel sits in the low byte of the encoding.
    localparam logic [15:0] WIDTH_RST    = 16'h0280;
    localparam logic [15:0] HEIGHT_RST   = 16'h01e0;
    localparam logic [15:0] ENCODING_RST = 16'h0108;
    localparam logic [NUM_GROUPS-1:0] GROUP_STATE_RST = 5'h1f;
    localparam int BPP_LSB = 0;
    localparam int BPP_MSB = 7;
    localparam logic [31:0] LOCK_ON = 32'h1;

    // Payload and container layout; the version value is arbitrary.
    localparam logic [31:0] HDR_VERSION    = 32'h0001_0000;
    localparam logic [31:0] HDR_BYTES      = 32'h0000_0040;
    localparam logic [31:0] ENLARGED_BYTES = 32'h0000_0100;
    localparam logic [31:0] COMPONENTS     = 32'h0000_0001;
    localparam logic [31:0] PARTS          = 32'h0000_0001;
    localparam logic [31:0] FLOW_COUNT     = 32'h0000_0001;
    localparam logic [31:0] FLOW_OFFSET    = 32'h0000_0000;
    localparam logic [31:0] TRAILER_BYTES [NUM_CH] = '{32'h40, 32'h80};
    localparam int HW_VERSION = 0;
    localparam int HW_SIZE    = 1;
    localparam int HW_COMPS   = 2;
    localparam int HW_PARTS   = 3;
    localparam int HW_OFFSET  = 4;
    localparam int FW_VERSION = 0;
    localparam int FW_COUNT   = 1;
    localparam int FW_SIZE    = 2;
    localparam int FW_OFFSET  = 3;

endpackage

/* File: rtl/tpl_cfg_if.sv */
// Settings carried from the lock bank to each payload calculator.
// Assumes source and calculators share one clock.
interface tpl_cfg_if;
    logic [15:0] width;
    logic [15:0] height;
    logic [7:0]  bpp;
    logic        enlarged;
    logic        containerOn;
    logic        freeze;
    modport src  (output width, height, bpp, enlarged, containerOn, freeze);
    modport calc (input  width, height, bpp, enlarged, containerOn, freeze);
endinterface

/* File: rtl/tpl_payload_calc.sv */
// Per stream channel byte count, header preview and flow map table.
// Assumes the settings in cfg are stable flops of the lock bank.
module tpl_payload_calc
    import tpl_pkg::*;
#(
    parameter int CH = 0
) (
    // Clock, reset and enable.
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  ce,
    // Settings from the bank.
    tpl_cfg_if.calc                    cfg,
    // Word pickers and results.
    input  wire logic [HDR_IDX_W-1:0]  hdrIdx,
    input  wire logic [FLOW_IDX_W-1:0] flowIdx,
    output logic      [31:0]           byteCount,
    output logic      [31:0]           hdrWord,
    output logic      [31:0]           flowWord
);

    logic [39:0] pixBits;
    logic [31:0] next_count;
    logic [31:0] next_hdr  [HDR_WORDS];
    logic [31:0] next_flow [FLOW_WORDS];
    logic [31:0] hdrMem    [HDR_WORDS];
    logic [31:0] flowMem   [FLOW_WORDS];

    // Image bytes plus enlarged part, trailer stamps and container header.
    always_comb begin
        pixBits = 40'(cfg.width) * 40'(cfg.height) * 40'(cfg.bpp);
        next_count = 32'(pixBits >> 3) + TRAILER_BYTES[CH]
                   + (cfg.enlarged ? ENLARGED_BYTES : 32'h0)
                   + (cfg.containerOn ? HDR_BYTES : 32'h0);
        for (int i = 0; i < HDR_WORDS; i++) begin
            next_hdr[i] = 32'h0;
        end
        for (int i = 0; i < FLOW_WORDS; i++) begin
            next_flow[i] = 32'h0;
        end
        // The count is the largest buffer, so variable containers fit.
        next_hdr[HW_VERSION]   = HDR_VERSION;
        next_hdr[HW_SIZE]      = next_count;
        next_hdr[HW_COMPS]     = COMPONENTS;
        next_hdr[HW_PARTS]     = PARTS;
        next_hdr[HW_OFFSET]    = HDR_BYTES;
        next_flow[FW_VERSION]  = HDR_VERSION;
        next_flow[FW_COUNT]    = FLOW_COUNT;
        next_flow[FW_SIZE]     = next_count;
        next_flow[FW_OFFSET]   = FLOW_OFFSET;
    end

    // All three follow the settings together and hold once frozen.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            byteCount <= 32'h0;
            for (int i = 0; i < HDR_WORDS; i++) begin
                hdrMem[i] <= 32'h0;
            end
            for (int i = 0; i < FLOW_WORDS; i++) begin
                flowMem[i] <= 32'h0;
            end
        end else if (ce && !cfg.freeze) begin
            byteCount <= next_count;
            hdrMem    <= next_hdr;
            flowMem   <= next_flow;
        end
    end

    // Read words are registered to keep the outputs glitch free.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hdrWord  <= 32'h0;
            flowWord <= 32'h0;
        end else if (ce) begin
            hdrWord  <= hdrMem[hdrIdx];
            flowWord <= flowMem[flowIdx];
        end
    end

endmodule

/* File: sim/tpl_acq_model.sv */
// Acquisition logic partner: ends a capture a few cycles after it starts.
// Assumes the bank clock and the bench's falling-edge drive convention.
module tpl_acq_model (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic sys_rst,
    // Capture start seen and capture end returned.
    input  wire logic captureGo,
    output logic      captureEnd = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] left = 3'h0;
    // A short capture keeps the run brief but still spans one write.
    always @(negedge clk) begin
        if (sys_rst) begin
            left <= 3'h0;
        end else if (captureGo) begin
            left <= 3'h4;
        end else if (left != 3'h0) begin
            left <= left - 3'h1;
        end
        captureEnd <= !sys_rst && (left == 3'h1);
    end
endmodule

/* File: sim/tpl_lock_bank_test.sv */
// Self-checking bench for the transport lock bank.
// Assumes the bank answers every request one cycle after it is taken.
module tpl_lock_bank_test import tpl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, sys_rst = 1, setReq = 0, setInternal = 0;
    logic rdReq = 0, captureBeginReq = 0, lineScan = 0;
    logic transferBeginReq = 0, autoPrefer = 0, headerVariable = 0;
    tpl_diag_e diag = DIAG_OFF;
    tpl_setting_e setSel = SET_LOCK, rdSel = SET_LOCK;
    logic [31:0] setData = 32'h0;
    logic [HDR_IDX_W-1:0] hdrIdx = 3'h0;
    logic [FLOW_IDX_W-1:0] flowIdx = 2'h0;
    logic setDone, setErr, rdValid, captureBeginGo, cmdRefused, captureEnd;
    logic transferBeginGo, streamAsContainer, hdrAvail, flowAvail;
    logic [31:0] rdData, bufferByteCount, hdrWord, flowWord;
    int mismatches = 0, n_tests = 0;
    // Bank; only the clock enable is tied, and it stays high.
    tpl_lock_bank tpl_lock_bank_inst (.clk, .sys_rst, .ce(1'b1), .setReq,
        .setInternal, .setSel, .setData, .setDone, .setErr, .rdReq, .rdSel,
        .rdData, .rdValid, .captureBeginReq, .transferBeginReq,
        .captureEnd, .captureBeginGo, .transferBeginGo, .cmdRefused,
        .lineScan, .autoPrefer, .headerVariable,
        .diagnosticPayloadFormat(diag), .transportParamLock(),
        .groupLocked(), .pixelWidth(), .pixelHeight(), .pixelEncoding(),
        .enlargedPayload(), .containerFormatActive(), .streamAsContainer,
        .bufferByteCount, .hdrIdx, .hdrWord, .hdrAvail, .flowIdx,
        .flowWord, .flowAvail);
    tpl_acq_model tpl_acq_model_inst (.clk, .sys_rst,
        .captureGo(captureBeginGo), .captureEnd);
    // Clock at 25 MHz.
    always #20 clk = ~clk;
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input tpl_setting_e s, input logic [31:0] d,
                      input logic e);
        @(negedge clk) setReq = 1;
        setSel = s;
        setData = d;
        @(negedge clk) setReq = 0;
        chk({setDone, setErr}, {1'b1, e});
    endtask
    task automatic rd(input tpl_setting_e s, input logic [31:0] e);
        @(negedge clk) rdReq = 1;
        rdSel = s;
        @(negedge clk) rdReq = 0;
        chk({rdValid, rdData}, {1'b1, e});
    endtask
    task automatic cap(input logic go);
        @(negedge clk) captureBeginReq = 1;
        transferBeginReq = 1;
        @(negedge clk) captureBeginReq = 0;
        transferBeginReq = 0;
        chk({captureBeginGo, transferBeginGo, cmdRefused}, {go, go, ~go});
    endtask
    task automatic conclude;
        $display("compared %0d, mismatched %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Hang guard: the sequence needs far fewer cycles than this.
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        $display("[ERR] %0t run too long", $time);
        conclude;
    end
    // Main sequence; counts settle a few cycles after each change.
    initial begin
        repeat (10) @(negedge clk);
        sys_rst = 0;
        rd(SET_WIDTH, 32'h280);
        rd(SET_ENCODING, 32'h108);
        rd(SET_LOCK, 32'h0);
        chk({hdrAvail, flowAvail, streamAsContainer}, 3'h0);
        cap(1'b0);
        wr(SET_WIDTH, 32'h10, 1'b0);
        wr(SET_HEIGHT, 32'h8, 1'b0);
        wr(SET_GROUP_SEL, 32'h1, 1'b0);
        wr(SET_GROUP_STATE, 32'h0, 1'b0);
        wr(SET_BYTE_COUNT, 32'h0, 1'b1);
        repeat (3) @(negedge clk);
        chk(bufferByteCount, 32'hc0);
        wr(SET_MODE, 32'h1, 1'b0);
        wr(SET_MODE, 32'h3, 1'b1);
        hdrIdx = HDR_IDX_W'(HW_SIZE);
        flowIdx = FLOW_IDX_W'(FW_SIZE);
        repeat (3) @(negedge clk);
        chk(bufferByteCount, 32'h100);
        rd(SET_STATUS, 32'h1);
        chk(streamAsContainer, 1'b1);
        diag = DIAG_MULTIPART;
        @(negedge clk);
        chk(streamAsContainer, 1'b0);
        diag = DIAG_OFF;
        chk({hdrAvail, flowAvail}, 2'b11);
        headerVariable = 1;
        @(negedge clk);
        chk({hdrAvail, flowAvail}, 2'b01);
        headerVariable = 0;
        chk(hdrWord, 32'h100);
        chk(flowWord, 32'h100);
        wr(SET_CHANNEL, 32'h1, 1'b0);
        repeat (3) @(negedge clk);
        chk(bufferByteCount, 32'h140);
        wr(SET_CHANNEL, 32'h0, 1'b0);
        wr(SET_MODE, 32'h2, 1'b0);
        rd(SET_STATUS, 32'h0);
        autoPrefer = 1;
        rd(SET_STATUS, 32'h1);
        $display("test unlocked settings done");
        wr(SET_LOCK, 32'h1, 1'b0);
        wr(SET_WIDTH, 32'h20, 1'b1);
        wr(SET_HEIGHT, 32'h20, 1'b1);
        lineScan = 1;
        wr(SET_HEIGHT, 32'h20, 1'b0);
        lineScan = 0;
        wr(SET_ENCODING, 32'h208, 1'b0);
        wr(SET_ENCODING, 32'h210, 1'b1);
        wr(SET_ENLARGED, 32'h1, 1'b1);
        setInternal = 1;
        wr(SET_WIDTH, 32'h20, 1'b1);
        wr(SET_ENLARGED, 32'h1, 1'b1);
        setInternal = 0;
        repeat (3) @(negedge clk);
        chk(bufferByteCount, 32'h100);
        chk(hdrWord, 32'h100);
        cap(1'b1);
        wr(SET_LOCK, 32'h0, 1'b1);
        repeat (8) @(negedge clk);
        wr(SET_LOCK, 32'h0, 1'b0);
        hdrIdx = HDR_IDX_W'(HW_VERSION);
        repeat (2) @(negedge clk);
        chk(hdrWord, HDR_VERSION);
        $display("test locked settings done");
        conclude;
    end
endmodule
